// [rtl/pmx_regs.svh]
// register offsets, field positions, reset values and strap codes of the
// programmable function pin multiplexer.
// assumes byte addressing on a 32-bit avalon slave, one word per register.
`ifndef PMX_REGS_SVH
`define PMX_REGS_SVH

// register byte offsets
`define PMX_REG_MODE 5'h00
`define PMX_REG_HOSTADDR 5'h04
`define PMX_REG_PORTSTAT 5'h08
`define PMX_REG_GPIO_OUT 5'h0C
`define PMX_REG_GPIO_OE 5'h10
`define PMX_REG_GPIO_IN 5'h14
`define PMX_REG_SERIAL 5'h18

// hub address register fields: usb 2.0 in [6:0], usb 3.1 gen 1 in [14:8]
`define PMX_USB2_ADDR_LSB 0
`define PMX_USB3_ADDR_LSB 8
// port status: speed pairs in [7:0], charge pairs in [15:8], two bits a port
`define PMX_SPEED_LSB 0
`define PMX_CHARGE_LSB 8
// serial control bits: request-to-send and terminal-ready asserted
`define PMX_SER_RTS_BIT 0
`define PMX_SER_DTR_BIT 1
// serial status bits: clear-to-send, carrier-detect, set-ready asserted
`define PMX_SER_CTS_BIT 8
`define PMX_SER_DCD_BIT 9
`define PMX_SER_DSR_BIT 10

// reset values
`define PMX_HOSTADDR_RST 16'h0000
`define PMX_PORTSTAT_RST 16'h0000
`define PMX_GPIO_OUT_RST 7'h00
`define PMX_GPIO_OE_RST 7'h00
`define PMX_SERIAL_RST 2'h0

// decoded strap codes from the resistor sense front end
`define PMX_STRAP_SPEED 3'h3
`define PMX_STRAP_GPIO 3'h4
`define PMX_STRAP_CHARGE 3'h5
`define PMX_STRAP_SERIAL 3'h6

`endif

// [rtl/pmx_pkg.sv]
// types shared by the programmable function pin multiplexer.
// assumes the constants of pmx_regs.svh are included where needed.
package pmx_pkg;

  // pin assignment selected by the strap
  typedef enum logic [2:0] {
    PMX_MODE_NONE,
    PMX_MODE_SPEED,
    PMX_MODE_GPIO,
    PMX_MODE_CHARGE,
    PMX_MODE_SERIAL
  } pmx_mode_t;

  // seven function pins, index 0 is pin 1
  typedef struct packed {
    logic [6:0] out;
    logic [6:0] oe;
  } pmx_pins_t;

  // open-drain management lines
  typedef struct packed {
    logic mgmt_serial_data;
    logic mgmt_serial_clock;
  } pmx_od_t;

  // avalon-mm request from the master
  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } pmx_av_req_t;

endpackage

// [rtl/pmx_pin_mux.sv]
// programmable function pin multiplexer for strap configurations 3 to 6,
// with its avalon-mm register slave.
// assumes one clock, a synchronous active-low reset and pin inputs that are
// already synchronous to clk_sys; pads resolve out/oe into the wire level.
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "pmx_regs.svh"

// Function
// - the strap code selects speed, gpio, charging or full serial mode.
// - speed mode drives pins 1,2,3,6 as port 1-4 speed: off, low for 2.0/1.1, high for gen 1.
// - speed mode drives pin 7 with host type: off, low for a gen 1 host, high for 2.0/1.1.
// - a usb 2.0 host counts as present when its hub address is non-zero.
// - a gen 1 host counts as present when its hub address is non-zero.
// - speed and serial modes route pins 4 and 5 to the open-drain management lines.
// - gpio mode makes all seven pins bidirectional general-purpose lines.
// - gpio mode maps pins 1-7 to general lines 1,2,3,6,8,10,11.
// - charging mode drives pins 1-4: off when disabled, low in bc 1.2, high when enabled.
// - charging mode makes pins 5-7 general lines 8,10,11.
// - serial mode puts rts on 1, cts on 2, dcd on 3, dtr on 6 and dsr on 7.
module pmx_pin_mux (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // strap code from the resistor sense front end
  input wire logic [2:0] strap_sel,
  // avalon-mm slave
  input wire pmx_pkg::pmx_av_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // function pins
  input wire logic [6:0] pin_in,
  output pmx_pkg::pmx_pins_t pins,
  // management serial core side
  input wire pmx_pkg::pmx_od_t mgmt_drive_low,
  output pmx_pkg::pmx_od_t mgmt_line
);
  import pmx_pkg::*;

  // byte-lane merge of a write into a register word
  function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // latched configuration
  pmx_mode_t mode_r;
  pmx_mode_t mode_nxt;
  logic cfg_valid_r;

  // software registers
  logic [15:0] hostaddr_r;
  logic [15:0] portstat_r;
  logic [6:0] gpio_out_r;
  logic [6:0] gpio_oe_r;
  logic [1:0] serial_r;
  logic [31:0] readdata_r;
  logic ack_r;

  // pin drive
  pmx_pins_t pins_r;
  pmx_pins_t pins_nxt;

  // strap decode into a mode; anything else leaves the pins floating
  always_comb begin
    case (strap_sel)
      `PMX_STRAP_SPEED: mode_nxt = PMX_MODE_SPEED;
      `PMX_STRAP_GPIO: mode_nxt = PMX_MODE_GPIO;
      `PMX_STRAP_CHARGE: mode_nxt = PMX_MODE_CHARGE;
      `PMX_STRAP_SERIAL: mode_nxt = PMX_MODE_SERIAL;
      default: mode_nxt = PMX_MODE_NONE;
    endcase
  end

  // take the strap on the first edge after release and never again
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mode_r <= PMX_MODE_NONE;
      cfg_valid_r <= 1'b0;
    end else if (!cfg_valid_r) begin
      mode_r <= mode_nxt;
      cfg_valid_r <= 1'b1;
    end
  end

  // mode flags
  wire is_speed = (mode_r == PMX_MODE_SPEED);
  wire is_gpio = (mode_r == PMX_MODE_GPIO);
  wire is_charge = (mode_r == PMX_MODE_CHARGE);
  wire is_serial = (mode_r == PMX_MODE_SERIAL);

  // host presence from the two hub address registers
  wire [6:0] usb2_addr = hostaddr_r[`PMX_USB2_ADDR_LSB +: 7];
  wire [6:0] usb3_addr = hostaddr_r[`PMX_USB3_ADDR_LSB +: 7];
  wire usb2_host = (usb2_addr != 7'h00);
  wire usb3_host = (usb3_addr != 7'h00);

  // per-port pairs: bit 0 drives the pin, bit 1 is its level
  wire [7:0] speed_st = portstat_r[`PMX_SPEED_LSB +: 8];
  wire [7:0] charge_st = portstat_r[`PMX_CHARGE_LSB +: 8];

  // serial control, asserted means pin low
  wire rts_on = serial_r[`PMX_SER_RTS_BIT];
  wire dtr_on = serial_r[`PMX_SER_DTR_BIT];
  // inputs read as asserted on a low level; floating pins would read random
  wire cts_on = is_serial & ~pin_in[1];
  wire dcd_on = is_serial & ~pin_in[2];
  wire dsr_on = is_serial & ~pin_in[6];

  // pin selection per mode
  always_comb begin
    pins_nxt.out = 7'h00;
    pins_nxt.oe = 7'h00;
    case (mode_r)
      PMX_MODE_SPEED: begin
        pins_nxt.oe[0] = speed_st[0];
        pins_nxt.out[0] = speed_st[1];
        pins_nxt.oe[1] = speed_st[2];
        pins_nxt.out[1] = speed_st[3];
        pins_nxt.oe[2] = speed_st[4];
        pins_nxt.out[2] = speed_st[5];
        pins_nxt.oe[5] = speed_st[6];
        pins_nxt.out[5] = speed_st[7];
        // gen 1 wins when both addresses are set: the link trained at 5g
        pins_nxt.oe[6] = usb2_host | usb3_host;
        pins_nxt.out[6] = ~usb3_host;
        pins_nxt.oe[3] = mgmt_drive_low.mgmt_serial_data;
        pins_nxt.oe[4] = mgmt_drive_low.mgmt_serial_clock;
      end
      PMX_MODE_GPIO: begin
        pins_nxt.out = gpio_out_r;
        pins_nxt.oe = gpio_oe_r;
      end
      PMX_MODE_CHARGE: begin
        for (int p = 0; p < 4; p++) begin
          pins_nxt.oe[p] = charge_st[2*p];
          pins_nxt.out[p] = charge_st[2*p+1];
        end
        pins_nxt.out[6:4] = gpio_out_r[6:4];
        pins_nxt.oe[6:4] = gpio_oe_r[6:4];
      end
      PMX_MODE_SERIAL: begin
        pins_nxt.oe[0] = 1'b1;
        pins_nxt.out[0] = ~rts_on;
        pins_nxt.oe[5] = 1'b1;
        pins_nxt.out[5] = ~dtr_on;
        pins_nxt.oe[3] = mgmt_drive_low.mgmt_serial_data;
        pins_nxt.oe[4] = mgmt_drive_low.mgmt_serial_clock;
      end
      default: begin
        pins_nxt.out = 7'h00;
        pins_nxt.oe = 7'h00;
      end
    endcase
  end

  // registered pin drive, all floating in reset
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pins_r <= '0;
    end else begin
      pins_r <= pins_nxt;
    end
  end

  assign pins = pins_r;

  // management line levels seen by the serial core; released high elsewhere
  wire mgmt_routed = is_speed | is_serial;
  assign mgmt_line.mgmt_serial_data = mgmt_routed ? pin_in[3] : 1'b1;
  assign mgmt_line.mgmt_serial_clock = mgmt_routed ? pin_in[4] : 1'b1;

  // bus decode: one wait state, answer on the cycle after the request
  wire avs_req_on = avs_req.read | avs_req.write;
  wire [4:0] avs_off = {avs_req.address[4:2], 2'b00};
  wire wr_go = ack_r & avs_req.write;
  wire sel_hostaddr = (avs_off == `PMX_REG_HOSTADDR);
  wire sel_portstat = (avs_off == `PMX_REG_PORTSTAT);
  wire sel_gpio_out = (avs_off == `PMX_REG_GPIO_OUT);
  wire sel_gpio_oe = (avs_off == `PMX_REG_GPIO_OE);
  wire sel_serial = (avs_off == `PMX_REG_SERIAL);
  wire [31:0] wmerge_hostaddr = be_merge({16'h0000, hostaddr_r}, avs_req.writedata,
                                         avs_req.byteenable);
  wire [31:0] wmerge_portstat = be_merge({16'h0000, portstat_r}, avs_req.writedata,
                                         avs_req.byteenable);
  wire [31:0] wmerge_gpio_out = be_merge({25'h0, gpio_out_r}, avs_req.writedata,
                                         avs_req.byteenable);
  wire [31:0] wmerge_gpio_oe = be_merge({25'h0, gpio_oe_r}, avs_req.writedata,
                                        avs_req.byteenable);
  wire [31:0] wmerge_serial = be_merge({30'h0, serial_r}, avs_req.writedata,
                                       avs_req.byteenable);

  // read word; unmapped offsets read zero
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h00000000;
    case (avs_off)
      `PMX_REG_MODE: rd_word = {23'h0, cfg_valid_r, 5'h00, mode_r};
      `PMX_REG_HOSTADDR: rd_word = {16'h0000, hostaddr_r};
      `PMX_REG_PORTSTAT: rd_word = {16'h0000, portstat_r};
      `PMX_REG_GPIO_OUT: rd_word = {25'h0, gpio_out_r};
      `PMX_REG_GPIO_OE: rd_word = {25'h0, gpio_oe_r};
      `PMX_REG_GPIO_IN: rd_word = {25'h0, pin_in};
      `PMX_REG_SERIAL: rd_word = {21'h0, dsr_on, dcd_on, cts_on, 6'h00, serial_r};
      default: rd_word = 32'h00000000;
    endcase
  end

  // handshake and read capture
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      readdata_r <= 32'h00000000;
    end else begin
      ack_r <= avs_req_on & ~ack_r;
      if (avs_req.read & ~ack_r) begin
        readdata_r <= rd_word;
      end
    end
  end

  assign avs_waitrequest = avs_req_on & ~ack_r;
  assign avs_readdata = readdata_r;

  // writable registers; writes to read-only or unmapped offsets are dropped
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hostaddr_r <= `PMX_HOSTADDR_RST;
      portstat_r <= `PMX_PORTSTAT_RST;
      gpio_out_r <= `PMX_GPIO_OUT_RST;
      gpio_oe_r <= `PMX_GPIO_OE_RST;
      serial_r <= `PMX_SERIAL_RST;
    end else if (wr_go) begin
      if (sel_hostaddr) begin
        hostaddr_r <= wmerge_hostaddr[15:0] & 16'h7F7F;
      end
      if (sel_portstat) begin
        portstat_r <= wmerge_portstat[15:0];
      end
      if (sel_gpio_out) begin
        gpio_out_r <= wmerge_gpio_out[6:0];
      end
      if (sel_gpio_oe) begin
        gpio_oe_r <= wmerge_gpio_oe[6:0];
      end
      if (sel_serial) begin
        serial_r <= wmerge_serial[1:0];
      end
    end
  end

  // checks on the pin mapping and the bus answer
  sequence s_bus_wait;
    avs_req_on && avs_waitrequest;
  endsequence

  sequence s_bus_done;
    !avs_waitrequest && ack_r;
  endsequence

  a_bus_one_wait: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_bus_wait |=> s_bus_done)
    else $error("bus answer not given one cycle after the request");

  a_strap_held_once: assert property (@(posedge clk_sys) disable iff (!resetn)
    cfg_valid_r |=> cfg_valid_r && $stable(mode_r))
    else $error("strap configuration changed after it was sampled");

  a_speed_pins_out: assert property (@(posedge clk_sys) disable iff (!resetn)
    is_speed |=> pins.oe[1] == $past(speed_st[2]) && pins.out[5] == $past(speed_st[7])
      && pins.oe[5] == $past(speed_st[6]) && pins.out[0] == $past(speed_st[1]))
    else $error("speed indicator pin does not follow port status");

  a_host_usb2_high: assert property (@(posedge clk_sys) disable iff (!resetn)
    is_speed && usb2_addr != 7'h00 && usb3_addr == 7'h00 |=> pins.oe[6] && pins.out[6])
    else $error("usb 2.0 host not shown high on pin 7");

  a_host_gen1_low: assert property (@(posedge clk_sys) disable iff (!resetn)
    is_speed && usb3_addr != 7'h00 |=> pins.oe[6] && !pins.out[6])
    else $error("gen 1 host not shown low on pin 7");

  a_host_none_off: assert property (@(posedge clk_sys) disable iff (!resetn)
    is_speed && hostaddr_r == 16'h0000 |=> !pins.oe[6])
    else $error("pin 7 driven with no host present");

  a_mgmt_open_drain: assert property (@(posedge clk_sys) disable iff (!resetn)
    (is_speed || is_serial) |=> !pins.out[3] && !pins.out[4]
      && pins.oe[3] == $past(mgmt_drive_low.mgmt_serial_data)
      && pins.oe[4] == $past(mgmt_drive_low.mgmt_serial_clock))
    else $error("management lines not routed open-drain to pins 4 and 5");

  a_gpio_all_pins: assert property (@(posedge clk_sys) disable iff (!resetn)
    is_gpio |=> pins.oe == $past(gpio_oe_r) && pins.out == $past(gpio_out_r))
    else $error("gpio mode pins do not follow general io registers");

  a_charge_pins_out: assert property (@(posedge clk_sys) disable iff (!resetn)
    is_charge |=> pins.oe[3:0] == {$past(charge_st[6]), $past(charge_st[4]),
      $past(charge_st[2]), $past(charge_st[0])} && pins.out[3] == $past(charge_st[7]))
    else $error("charge indicator pins do not follow port status");

  a_charge_gpio_hi: assert property (@(posedge clk_sys) disable iff (!resetn)
    is_charge |=> pins.oe[6:4] == $past(gpio_oe_r[6:4])
      && pins.out[6:4] == $past(gpio_out_r[6:4]))
    else $error("charge mode pins 5 to 7 not general io");

  a_charge_levels: assert property (@(posedge clk_sys) disable iff (!resetn)
    is_charge |=> pins.out[2:0] == {$past(charge_st[5]), $past(charge_st[3]),
      $past(charge_st[1])})
    else $error("charge indicator level does not follow port status");

  a_serial_rts_low: assert property (@(posedge clk_sys) disable iff (!resetn)
    is_serial && rts_on |=> pins.oe[0] && !pins.out[0] && !pins.oe[1] && !pins.oe[6])
    else $error("asserted rts not driven low on pin 1");

  a_serial_dtr_low: assert property (@(posedge clk_sys) disable iff (!resetn)
    is_serial && dtr_on |=> pins.oe[5] && !pins.out[5])
    else $error("asserted dtr not driven low on pin 6");

  a_serial_idle_high: assert property (@(posedge clk_sys) disable iff (!resetn)
    is_serial && !rts_on && !dtr_on |=> pins.oe[0] && pins.out[0] && pins.oe[5] && pins.out[5])
    else $error("negated rts or dtr not driven high");

  // a status read taken in serial mode; the answer stands one edge later
  sequence s_serial_rd_taken;
    avs_req.read && avs_waitrequest && avs_off == `PMX_REG_SERIAL && is_serial;
  endsequence

  a_serial_status_rd: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_serial_rd_taken |=> avs_readdata[`PMX_SER_CTS_BIT] == !$past(pin_in[1])
      && avs_readdata[`PMX_SER_DSR_BIT] == !$past(pin_in[6]))
    else $error("modem status not read back as active low");

  a_none_all_float: assert property (@(posedge clk_sys) disable iff (!resetn)
    cfg_valid_r && mode_r == PMX_MODE_NONE |=> pins.oe == 7'h00)
    else $error("pin driven with no strap function selected");

  // no disable here: the reset edge itself is what is checked
  a_reset_pins_float: assert property (@(posedge clk_sys)
    !resetn |=> pins.oe == 7'h00 && pins.out == 7'h00)
    else $error("function pins driven after a reset edge");

endmodule

// [bench/pmx_board.sv]
// board around the seven function pins: loads, pulls and a serial partner.
// assumes the device drives out/oe per pin and reads back the wire level.
`timescale 1ns/100ps
module pmx_board (
  // clock for the floating-line pattern
  input wire logic clk_sys,
  // device side of the pins
  input wire pmx_pkg::pmx_pins_t pins,
  // board drivers, a gpio load or the modem partner
  input wire logic [6:0] ext_val,
  input wire logic [6:0] ext_oe,
  // resolved wire level back to the device
  output logic [6:0] pin_lvl
);
  import pmx_pkg::*;
  // pulls fitted on the board
  // pull-ups on the open-drain lines, pins 4 and 5
  // pull-downs on clear-to-send, carrier-detect, set-ready
  logic [6:0] pull_en;
  logic [6:0] pull_lvl;
  logic [6:0] float_r = 7'h2A;
  assign pull_en = 7'h5E;
  assign pull_lvl = 7'h18;
  // an undriven, unpulled pin wanders, so a stale level never passes for data
  always @(posedge clk_sys) begin
    float_r <= ~float_r;
  end
  // device wins, then board driver, then pull, else wandering level
  assign pin_lvl = (pins.oe & pins.out) | (~pins.oe & ext_oe & ext_val)
    | (~pins.oe & ~ext_oe & pull_en & pull_lvl)
    | (~pins.oe & ~ext_oe & ~pull_en & float_r);
endmodule

// [bench/tb.sv]
// self-checking bench for the function pin multiplexer, one task a mode.
// assumes the board model on the pins and the avalon slave of the design.
`timescale 1ns/100ps
`include "pmx_regs.svh"
module tb;
  import pmx_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] strap_sel = 3'h0;
  pmx_av_req_t avs_req = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [6:0] pin_in;
  logic [6:0] ext_val = 7'h00;
  logic [6:0] ext_oe = 7'h00;
  pmx_pins_t pins;
  pmx_od_t mgmt_drive_low = '0;
  pmx_od_t mgmt_line;
  logic [31:0] q;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;

  always #50 clk_sys = ~clk_sys;

  pmx_pin_mux i_pmx_pin_mux (.clk_sys(clk_sys), .resetn(resetn), .strap_sel(strap_sel),
    .avs_req(avs_req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_in(pin_in), .pins(pins), .mgmt_drive_low(mgmt_drive_low), .mgmt_line(mgmt_line));
  pmx_board i_pmx_board (.clk_sys(clk_sys), .pins(pins), .ext_val(ext_val),
    .ext_oe(ext_oe), .pin_lvl(pin_in));

  task automatic complete_run;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // a hang ends the run with a counted mismatch
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      complete_run;
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one avalon transfer; held until waitrequest is sampled low at a rising edge,
  // read data taken at that edge; only the bench timeout ends a hung wait
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_req <= '{address: a, read: ~wr, write: wr, writedata: d, byteenable: 4'hF};
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask

  task automatic rd(input string what, input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, exp, q);
  endtask

  // pins follow one edge after a write lands; look mid-cycle
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic pin_chk(input string what, input logic [6:0] m, input logic [6:0] oe,
      input logic [6:0] out);
    check({what, " oe"}, {25'h0, oe}, {25'h0, pins.oe & m});
    check({what, " out"}, {25'h0, out & m & oe}, {25'h0, pins.out & m & oe});
  endtask

  task automatic start(input logic [2:0] s);
    @(posedge clk_sys);
    resetn <= 1'b0;
    strap_sel <= s;
    ext_oe <= 7'h00;
    mgmt_drive_low <= '0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    settle;
  endtask

  task automatic t_speed;
    logic [15:0] ha[4] = '{16'h0000, 16'h0005, 16'h0300, 16'h0305};
    // oe in bit 1, level in bit 0; a gen 1 address wins and shows low
    logic [1:0] hx[4] = '{2'b00, 2'b11, 2'b10, 2'b10};
    start(`PMX_STRAP_SPEED);
    rd("mode", `PMX_REG_MODE, 32'h100 | 32'(PMX_MODE_SPEED));
    rd("hostaddr reset", `PMX_REG_HOSTADDR, 32'h0);
    rd("portstat reset", `PMX_REG_PORTSTAT, 32'h0);
    pin_chk("speed idle", 7'h7F, 7'h00, 7'h00);
    bus(1'b1, `PMX_REG_PORTSTAT, 32'h0000_00CD);
    settle;
    pin_chk("speed ports", 7'h27, 7'h23, 7'h22);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `PMX_REG_HOSTADDR, {16'h0, ha[i]});
      settle;
      pin_chk("host type", 7'h40, {hx[i][1], 6'h0}, {hx[i][0], 6'h0});
    end
    @(posedge clk_sys);
    mgmt_drive_low <= '{mgmt_serial_data: 1'b1, mgmt_serial_clock: 1'b0};
    settle;
    pin_chk("mgmt low", 7'h18, 7'h08, 7'h00);
    check("mgmt line", 32'h1, {30'h0, mgmt_line});
    @(posedge clk_sys);
    mgmt_drive_low <= '0;
    strap_sel <= `PMX_STRAP_GPIO;
    settle;
    check("mgmt released", 32'h3, {30'h0, mgmt_line});
    bus(1'b1, `PMX_REG_MODE, 32'h0);
    rd("mode held", `PMX_REG_MODE, 32'h100 | 32'(PMX_MODE_SPEED));
    pin_chk("ports held", 7'h27, 7'h23, 7'h22);
    rd("unmapped", 5'h1C, 32'h0);
  endtask

  task automatic t_gpio;
    start(`PMX_STRAP_GPIO);
    rd("mode", `PMX_REG_MODE, 32'h100 | 32'(PMX_MODE_GPIO));
    bus(1'b1, `PMX_REG_GPIO_OE, 32'h7F);
    bus(1'b1, `PMX_REG_GPIO_OUT, 32'h55);
    settle;
    pin_chk("gpio out", 7'h7F, 7'h7F, 7'h55);
    check("mgmt off", 32'h3, {30'h0, mgmt_line});
    bus(1'b1, `PMX_REG_GPIO_OE, 32'h0);
    settle;
    @(posedge clk_sys);
    ext_oe <= 7'h7F;
    ext_val <= 7'h2A;
    settle;
    rd("gpio in", `PMX_REG_GPIO_IN, 32'h2A);
  endtask

  task automatic t_charge;
    start(`PMX_STRAP_CHARGE);
    rd("mode", `PMX_REG_MODE, 32'h100 | 32'(PMX_MODE_CHARGE));
    bus(1'b1, `PMX_REG_PORTSTAT, 32'h0000_8D00);
    bus(1'b1, `PMX_REG_GPIO_OE, 32'h7F);
    bus(1'b1, `PMX_REG_GPIO_OUT, 32'h7F);
    settle;
    pin_chk("charge pins", 7'h7F, 7'h73, 7'h72);
  endtask

  task automatic t_serial;
    start(`PMX_STRAP_SERIAL);
    rd("mode", `PMX_REG_MODE, 32'h100 | 32'(PMX_MODE_SERIAL));
    rd("serial idle", `PMX_REG_SERIAL, 32'h700);
    pin_chk("serial idle", 7'h67, 7'h21, 7'h21);
    bus(1'b1, `PMX_REG_SERIAL, 32'h1);
    settle;
    pin_chk("rts", 7'h21, 7'h21, 7'h20);
    bus(1'b1, `PMX_REG_SERIAL, 32'h2);
    settle;
    pin_chk("dtr", 7'h21, 7'h21, 7'h01);
    @(posedge clk_sys);
    ext_oe <= 7'h02;
    ext_val <= 7'h02;
    mgmt_drive_low <= '{mgmt_serial_data: 1'b0, mgmt_serial_clock: 1'b1};
    settle;
    rd("cts off", `PMX_REG_SERIAL, 32'h602);
    pin_chk("mgmt clock", 7'h18, 7'h10, 7'h00);
    check("mgmt line", 32'h2, {30'h0, mgmt_line});
  endtask

  task automatic t_none;
    start(3'h0);
    bus(1'b1, `PMX_REG_PORTSTAT, 32'h0000_FFFF);
    settle;
    pin_chk("no function", 7'h7F, 7'h00, 7'h00);
  endtask

  initial begin
    t_speed;
    t_gpio;
    t_charge;
    t_serial;
    t_none;
    complete_run;
  end
endmodule
